// ### design/isg_cfg.svh
// offsets, field positions, vectors and reset values of the gate entry/return unit
`ifndef ISG_CFG_SVH
`define ISG_CFG_SVH
`define ISG_ADR_CTRL      8'h00
`define ISG_ADR_STATUS    8'h04
`define ISG_ADR_FLAGS     8'h08
`define ISG_ADR_CODE_SEL  8'h0c
`define ISG_ADR_IP        8'h10
`define ISG_ADR_STK_SEL   8'h14
`define ISG_ADR_STK_PTR   8'h18
`define ISG_ADR_GATE_IDX  8'h1c
`define ISG_ADR_GATE_ATTR 8'h20
`define ISG_ADR_GATE_OFF  8'h24
`define ISG_ADR_TSS_BASE  8'h28
`define ISG_ADR_TSS_LAST  8'h3c
`define ISG_FLAG_IF       9
`define ISG_FLAGS_RST     32'h0000_0002
`define ISG_WORD_BYTES    32'h0000_0004
`define ISG_RET_FRAME     32'h0000_000c
`define ISG_ATTR_DPL_LO   16
`define ISG_ATTR_TRAP     18
`define ISG_ATTR_PRESENT  19
`define ISG_VEC_DIVIDE    8'h00
`define ISG_VEC_DEBUG     8'h01
`define ISG_VEC_NMI       8'h02
`define ISG_VEC_BREAK     8'h03
`define ISG_VEC_OVERFLOW  8'h04
`define ISG_VEC_RANGE     8'h05
`define ISG_VEC_INV_OP    8'h06
`define ISG_VEC_FPU_NA    8'h07
`define ISG_VEC_DOUBLE    8'h08
`define ISG_VEC_SEG_OVR   8'h09
`define ISG_VEC_INV_TSS   8'h0a
`define ISG_VEC_SEG_ABS   8'h0b
`define ISG_VEC_STACK     8'h0c
`define ISG_VEC_PROT      8'h0d
`define ISG_VEC_PAGING    8'h0e
`define ISG_VEC_RSV15     8'h0f
`define ISG_VEC_FPU_ERR   8'h10
`define ISG_VEC_ALIGN     8'h11
`define ISG_VEC_MCHECK    8'h12
`define ISG_VEC_SIMD      8'h13
`define ISG_VEC_RSV_LAST  8'h1f
`define ISG_VEC_USER_LO   8'h20
`endif

// ### design/isg_gate_unit.sv
// interrupt/trap gate dispatch and handler return unit with wishbone register file
//
// Overview of operation
// - interrupt gate entry clears interrupt enable flag
// - trap gate entry keeps interrupt enable flag
// - gate holds access rights, selector and offset
// - vectors 0 to 5 for first six events
// - invalid opcode 6, fpu unavailable 7
// - delivery failure raises double fault vector 8
// - vector 9 is never generated
// - task segment 10, absent 11, stack 12
// - protection fault 13, paging fault 14
// - fpu error 16, alignment 17, simd 19
// - machine check uses vector 18
// - vectors 32-255 from pin or software
// - same level keeps stack, higher switches stack
// - no switch: push flags, selector, pointer
// - error code pushed after saved return state
// - handler selector and pointer from gate
// - latch old state before switching stack
// - new stack loaded from task state segment
// - push five latched words, then error code
// - return acts as far return plus flags
// - same level return pops frame, adjusts pointer
// - cross level return checks, restores old stack
// - every event identified by a vector number
// - handler reached through vector table entry
`timescale 1ns/1ps
`include "isg_cfg.svh"

module isg_gate_unit
  import isg_pkg::*;
#(
  parameter int VECS = 256
) (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          wb_cyc,
  input  wire logic          wb_stb,
  input  wire logic          wb_we,
  input  wire logic [7:0]    wb_adr,
  input  wire logic [3:0]    wb_sel,
  input  wire logic [31:0]   wb_dat_w,
  output logic      [31:0]   wb_dat_r,
  output logic               wb_ack,
  input  wire logic          exc_valid,
  input  wire isg_cause_type exc_cause,
  input  wire logic [31:0]   exc_code,
  input  wire logic          swi_valid,
  input  wire logic [7:0]    swi_vec,
  input  wire logic          handler_return_instr,
  output logic               ev_ready,
  input  wire logic          maskable_request_pin,
  input  wire logic [7:0]    irq_vec,
  output logic               irq_ack,
  output logic               stk_cyc,
  output logic               stk_we,
  output logic      [31:0]   stk_adr,
  output logic      [31:0]   stk_dat_w,
  input  wire logic [31:0]   stk_dat_r,
  input  wire logic          stk_ack,
  input  wire logic          stk_err,
  output logic               handler_start,
  output logic               halted,
  output logic      [7:0]    cur_vec,
  output logic      [31:0]   flags_word,
  output logic      [15:0]   code_sel,
  output logic      [31:0]   instr_pointer,
  output logic      [1:0]    cur_level
);

  function automatic logic [7:0] cause_vec(input isg_cause_type c);
    case (c)
      CS_DIVIDE:        cause_vec = `ISG_VEC_DIVIDE;
      CS_DEBUG:         cause_vec = `ISG_VEC_DEBUG;
      CS_NMI:           cause_vec = `ISG_VEC_NMI;
      CS_BREAKPOINT:    cause_vec = `ISG_VEC_BREAK;
      CS_OVERFLOW:      cause_vec = `ISG_VEC_OVERFLOW;
      CS_RANGE:         cause_vec = `ISG_VEC_RANGE;
      CS_INVALID_OP:    cause_vec = `ISG_VEC_INV_OP;
      CS_FPU_UNAVAIL:   cause_vec = `ISG_VEC_FPU_NA;
      CS_INVALID_TSS:   cause_vec = `ISG_VEC_INV_TSS;
      CS_SEG_ABSENT:    cause_vec = `ISG_VEC_SEG_ABS;
      CS_STACK_FAULT:   cause_vec = `ISG_VEC_STACK;
      CS_PROTECTION:    cause_vec = `ISG_VEC_PROT;
      CS_PAGING:        cause_vec = `ISG_VEC_PAGING;
      CS_FPU_ERROR:     cause_vec = `ISG_VEC_FPU_ERR;
      CS_ALIGNMENT:     cause_vec = `ISG_VEC_ALIGN;
      CS_MACHINE_CHECK: cause_vec = `ISG_VEC_MCHECK;
      CS_SIMD_FP:       cause_vec = `ISG_VEC_SIMD;
      default:          cause_vec = `ISG_VEC_PROT;
    endcase
  endfunction

  // fixed table of vectors that carry an error code
  function automatic logic err_code_vec(input logic [7:0] v);
    err_code_vec = (v == `ISG_VEC_DOUBLE) || (v == `ISG_VEC_INV_TSS) ||
                   (v == `ISG_VEC_SEG_ABS) || (v == `ISG_VEC_STACK) ||
                   (v == `ISG_VEC_PROT) || (v == `ISG_VEC_PAGING) ||
                   (v == `ISG_VEC_ALIGN);
  endfunction

  function automatic logic rsv_vec(input logic [7:0] v);
    rsv_vec = (v == `ISG_VEC_SEG_OVR) || (v == `ISG_VEC_RSV15) ||
              ((v > `ISG_VEC_SIMD) && (v <= `ISG_VEC_RSV_LAST));
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bmerge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  isg_state_type state_r, state_nxt;
  logic [7:0]  vec_r, vec_nxt;
  logic [31:0] err_r, err_nxt;
  logic        has_err_r, has_err_nxt, soft_r, soft_nxt, switch_r, switch_nxt;
  logic [2:0]  idx_r, idx_nxt, cnt_r, cnt_nxt;
  logic [31:0] fl_r, fl_nxt, ip_r, ip_nxt, sp_r, sp_nxt;
  logic [15:0] cs_r, cs_nxt, ss_r, ss_nxt;
  logic [1:0]  cpl_r, cpl_nxt;
  logic [31:0] tfl_r, tfl_nxt, tip_r, tip_nxt, tsp_r, tsp_nxt;
  logic [15:0] tcs_r, tcs_nxt, tss_r, tss_nxt;
  logic        start_r, start_nxt, ack_r;
  logic [31:0] rdat_r;
  logic [7:0]  gidx_r;
  logic [15:0] tss_sel_r [3];
  logic [31:0] tss_sp_r  [3];
  logic [15:0] gate_sel_mem  [VECS];
  logic [31:0] gate_off_mem  [VECS];
  logic [2:0]  gate_attr_mem [VECS];
  logic [VECS-1:0] gate_ok_r;
  logic [1:0]  pin_sync_r, pin_s_r;
  logic [7:0]  vsync_r, vec_s_r;

  // gate lookup by vector
  wire [15:0] gate_sel     = gate_sel_mem[vec_r];
  wire [31:0] gate_off     = gate_off_mem[vec_r];
  wire [1:0]  gate_dpl     = gate_attr_mem[vec_r][1:0];
  wire        gate_trap    = gate_attr_mem[vec_r][2];
  wire        gate_present = gate_ok_r[vec_r];
  wire [1:0]  tcpl         = gate_sel[1:0];
  wire [1:0]  ret_rpl      = tcs_r[1:0];
  wire        ret_switch   = ret_rpl != cpl_r;
  wire        idle         = state_r == ST_IDLE;

  // register bus decode
  wire        wb_req  = wb_cyc & wb_stb & ~ack_r;
  wire        wb_wr   = wb_req & wb_we;
  wire        tss_hit = (wb_adr >= `ISG_ADR_TSS_BASE) && (wb_adr <= `ISG_ADR_TSS_LAST);
  wire [7:0]  tss_off = wb_adr - `ISG_ADR_TSS_BASE;
  wire [1:0]  tss_lvl = tss_off[4:3];
  wire        tss_sp  = tss_off[2];
  wire [31:0] gate_rd = {12'h000, gate_ok_r[gidx_r], gate_attr_mem[gidx_r][2],
                         gate_attr_mem[gidx_r][1:0], gate_sel_mem[gidx_r]};
  wire [31:0] tss_rd  = tss_sp ? tss_sp_r[tss_lvl] : {16'h0000, tss_sel_r[tss_lvl]};
  wire [31:0] status  = {16'h0000, vec_r, 4'h0, cpl_r, (state_r == ST_HALT), ~idle};
  assign wb_ack = ack_r;
  assign wb_dat_r = rdat_r;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `ISG_ADR_CTRL:      rd_mux = {30'h0, cpl_r};
      `ISG_ADR_STATUS:    rd_mux = status;
      `ISG_ADR_FLAGS:     rd_mux = fl_r;
      `ISG_ADR_CODE_SEL:  rd_mux = {16'h0000, cs_r};
      `ISG_ADR_IP:        rd_mux = ip_r;
      `ISG_ADR_STK_SEL:   rd_mux = {16'h0000, ss_r};
      `ISG_ADR_STK_PTR:   rd_mux = sp_r;
      `ISG_ADR_GATE_IDX:  rd_mux = {24'h0, gidx_r};
      `ISG_ADR_GATE_ATTR: rd_mux = gate_rd;
      `ISG_ADR_GATE_OFF:  rd_mux = gate_off_mem[gidx_r];
      default:            rd_mux = tss_hit ? tss_rd : 32'h0000_0000;
    endcase
  endfunction

  // pin crosses from the outside world through four flops, its vector through two
  wire take_irq = pin_s_r[1] & fl_r[`ISG_FLAG_IF] & (vec_s_r >= `ISG_VEC_USER_LO);
  assign ev_ready  = idle;
  assign irq_ack   = idle & ~exc_valid & ~swi_valid & ~handler_return_instr & take_irq;
  assign stk_cyc   = (state_r == ST_PUSH) | (state_r == ST_POP);
  assign stk_we    = state_r == ST_PUSH;
  assign stk_adr   = stk_we ? sp_r - `ISG_WORD_BYTES : sp_r + {27'h0, idx_r, 2'b00};

  // push order: with a switch the old stack words lead, without it flags lead
  wire [2:0] push_k = switch_r ? idx_r : idx_r + 3'd2;
  always_comb begin
    case (push_k)
      3'd0:    stk_dat_w = {16'h0000, tss_r};
      3'd1:    stk_dat_w = tsp_r;
      3'd2:    stk_dat_w = tfl_r;
      3'd3:    stk_dat_w = {16'h0000, tcs_r};
      3'd4:    stk_dat_w = tip_r;
      default: stk_dat_w = err_r;
    endcase
  end

  assign handler_start = start_r;
  assign halted        = state_r == ST_HALT;
  assign cur_vec       = vec_r;
  assign flags_word    = fl_r;
  assign code_sel      = cs_r;
  assign instr_pointer = ip_r;
  assign cur_level     = cpl_r;

  always_comb begin
    state_nxt = state_r; vec_nxt = vec_r; err_nxt = err_r; has_err_nxt = has_err_r;
    soft_nxt = soft_r; switch_nxt = switch_r; idx_nxt = idx_r; cnt_nxt = cnt_r;
    fl_nxt = fl_r; cs_nxt = cs_r; ip_nxt = ip_r; ss_nxt = ss_r; sp_nxt = sp_r;
    cpl_nxt = cpl_r; start_nxt = 1'b0;
    tfl_nxt = tfl_r; tcs_nxt = tcs_r; tip_nxt = tip_r; tss_nxt = tss_r; tsp_nxt = tsp_r;
    case (state_r)
      ST_IDLE: begin
        if (exc_valid) begin
          vec_nxt = cause_vec(exc_cause);
          err_nxt = exc_code;
          has_err_nxt = err_code_vec(vec_nxt);
          soft_nxt = 1'b0;
          state_nxt = ST_GATE;
        end else if (swi_valid) begin
          // a software call to a reserved slot turns into a protection fault
          vec_nxt = rsv_vec(swi_vec) ? `ISG_VEC_PROT : swi_vec;
          err_nxt = {21'h0, swi_vec, 3'b010};
          has_err_nxt = rsv_vec(swi_vec);
          soft_nxt = ~rsv_vec(swi_vec);
          state_nxt = ST_GATE;
        end else if (handler_return_instr) begin
          idx_nxt = 3'd0;
          state_nxt = ST_POP;
        end else if (take_irq) begin
          vec_nxt = vec_s_r;
          err_nxt = 32'h0000_0000;
          has_err_nxt = 1'b0;
          soft_nxt = 1'b0;
          state_nxt = ST_GATE;
        end else if (wb_wr) begin
          // architectural state is software-writable only while no event runs
          case (wb_adr)
            `ISG_ADR_CTRL:     cpl_nxt = wb_sel[0] ? wb_dat_w[1:0] : cpl_r;
            `ISG_ADR_FLAGS:    fl_nxt = bmerge(fl_r, wb_dat_w, wb_sel);
            `ISG_ADR_CODE_SEL: cs_nxt = 16'(bmerge({16'h0, cs_r}, wb_dat_w, wb_sel));
            `ISG_ADR_IP:       ip_nxt = bmerge(ip_r, wb_dat_w, wb_sel);
            `ISG_ADR_STK_SEL:  ss_nxt = 16'(bmerge({16'h0, ss_r}, wb_dat_w, wb_sel));
            `ISG_ADR_STK_PTR:  sp_nxt = bmerge(sp_r, wb_dat_w, wb_sel);
            default: ;
          endcase
        end
      end
      ST_GATE: begin
        if (!gate_present || tcpl > cpl_r) begin
          if (vec_r == `ISG_VEC_DOUBLE) state_nxt = ST_HALT;
          else begin
            vec_nxt = `ISG_VEC_DOUBLE;
            err_nxt = 32'h0000_0000;
            has_err_nxt = 1'b1;
            soft_nxt = 1'b0;
          end
        end else if (soft_r && gate_dpl < cpl_r) begin
          vec_nxt = `ISG_VEC_PROT;
          err_nxt = {21'h0, vec_r, 3'b010};
          has_err_nxt = 1'b1;
          soft_nxt = 1'b0;
        end else begin
          switch_nxt = tcpl < cpl_r;
          state_nxt = ST_SAVE;
        end
      end
      ST_SAVE: begin
        tss_nxt = ss_r; tsp_nxt = sp_r; tfl_nxt = fl_r;
        tcs_nxt = cs_r; tip_nxt = ip_r;
        if (switch_r) begin
          ss_nxt = tss_sel_r[tcpl];
          sp_nxt = tss_sp_r[tcpl];
        end
        cnt_nxt = (switch_r ? 3'd5 : 3'd3) + {2'b00, has_err_r};
        idx_nxt = 3'd0;
        state_nxt = ST_PUSH;
      end
      ST_PUSH: begin
        if (stk_err) begin
          ss_nxt = tss_r;
          sp_nxt = tsp_r;
          if (vec_r == `ISG_VEC_DOUBLE) state_nxt = ST_HALT;
          else begin
            vec_nxt = `ISG_VEC_DOUBLE;
            err_nxt = 32'h0000_0000;
            has_err_nxt = 1'b1;
            soft_nxt = 1'b0;
            state_nxt = ST_GATE;
          end
        end else if (stk_ack) begin
          sp_nxt = sp_r - `ISG_WORD_BYTES;
          idx_nxt = idx_r + 3'd1;
          if (idx_r + 3'd1 == cnt_r) state_nxt = ST_ENTER;
        end
      end
      ST_ENTER: begin
        cs_nxt = gate_sel;
        ip_nxt = gate_off;
        cpl_nxt = tcpl;
        if (!gate_trap) fl_nxt[`ISG_FLAG_IF] = 1'b0;
        start_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_POP: begin
        if (stk_err) begin
          vec_nxt = `ISG_VEC_STACK;
          err_nxt = 32'h0000_0000;
          has_err_nxt = 1'b1;
          soft_nxt = 1'b0;
          state_nxt = ST_GATE;
        end else if (stk_ack) begin
          idx_nxt = idx_r + 3'd1;
          case (idx_r)
            3'd0:    tip_nxt = stk_dat_r;
            3'd1:    tcs_nxt = stk_dat_r[15:0];
            3'd2:    tfl_nxt = stk_dat_r;
            3'd3:    tsp_nxt = stk_dat_r;
            default: tss_nxt = stk_dat_r[15:0];
          endcase
          if (idx_r == 3'd2 && ret_rpl < cpl_r) begin
            // returning to a more privileged level fails the check
            vec_nxt = `ISG_VEC_PROT;
            err_nxt = {16'h0000, tcs_r};
            has_err_nxt = 1'b1;
            soft_nxt = 1'b0;
            state_nxt = ST_GATE;
          end else if ((idx_r == 3'd2 && !ret_switch) || idx_r == 3'd4) begin
            state_nxt = ST_RET;
          end
        end
      end
      ST_RET: begin
        cs_nxt = tcs_r;
        ip_nxt = tip_r;
        fl_nxt = tfl_r;
        cpl_nxt = ret_rpl;
        if (ret_switch) begin
          ss_nxt = tss_r;
          sp_nxt = tsp_r;
        end else begin
          sp_nxt = sp_r + `ISG_RET_FRAME;
        end
        state_nxt = ST_IDLE;
      end
      ST_HALT: ;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE; vec_r <= 8'h00; err_r <= 32'h0; has_err_r <= 1'b0;
      soft_r <= 1'b0; switch_r <= 1'b0; idx_r <= 3'd0; cnt_r <= 3'd0;
      fl_r <= `ISG_FLAGS_RST; cs_r <= 16'h0; ip_r <= 32'h0; ss_r <= 16'h0;
      sp_r <= 32'h0; cpl_r <= 2'd0; start_r <= 1'b0;
      tfl_r <= 32'h0; tcs_r <= 16'h0; tip_r <= 32'h0; tss_r <= 16'h0; tsp_r <= 32'h0;
    end else begin
      state_r <= state_nxt; vec_r <= vec_nxt; err_r <= err_nxt; has_err_r <= has_err_nxt;
      soft_r <= soft_nxt; switch_r <= switch_nxt; idx_r <= idx_nxt; cnt_r <= cnt_nxt;
      fl_r <= fl_nxt; cs_r <= cs_nxt; ip_r <= ip_nxt; ss_r <= ss_nxt;
      sp_r <= sp_nxt; cpl_r <= cpl_nxt; start_r <= start_nxt;
      tfl_r <= tfl_nxt; tcs_r <= tcs_nxt; tip_r <= tip_nxt; tss_r <= tss_nxt; tsp_r <= tsp_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_r <= 2'b00; pin_s_r <= 2'b00; vsync_r <= 8'h00; vec_s_r <= 8'h00;
    end else begin
      pin_sync_r <= {pin_sync_r[0], maskable_request_pin};
      pin_s_r <= {pin_s_r[0], pin_sync_r[1]};
      vsync_r <= irq_vec;
      vec_s_r <= vsync_r;
    end
  end

  // bus slave: one wait state, ack for exactly one cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0; rdat_r <= 32'h0; gidx_r <= 8'h00; gate_ok_r <= '0;
      for (int i = 0; i < 3; i++) begin
        tss_sel_r[i] <= 16'h0;
        tss_sp_r[i] <= 32'h0;
      end
    end else begin
      ack_r <= wb_req;
      if (wb_req) rdat_r <= rd_mux(wb_adr);
      if (wb_wr && wb_adr == `ISG_ADR_GATE_IDX && wb_sel[0]) gidx_r <= wb_dat_w[7:0];
      if (wb_wr && wb_adr == `ISG_ADR_GATE_ATTR && wb_sel[2])
        gate_ok_r[gidx_r] <= wb_dat_w[`ISG_ATTR_PRESENT];
      if (wb_wr && tss_hit && tss_lvl != 2'd3) begin
        if (tss_sp) tss_sp_r[tss_lvl] <= bmerge(tss_sp_r[tss_lvl], wb_dat_w, wb_sel);
        else tss_sel_r[tss_lvl] <= 16'(bmerge({16'h0, tss_sel_r[tss_lvl]}, wb_dat_w, wb_sel));
      end
    end
  end

  // table storage carries no reset; the present bits guard stale entries
  always_ff @(posedge mclk) begin
    if (wb_wr && wb_adr == `ISG_ADR_GATE_ATTR) begin
      gate_sel_mem[gidx_r]  <= wb_dat_w[15:0];
      gate_attr_mem[gidx_r] <= {wb_dat_w[`ISG_ATTR_TRAP], wb_dat_w[`ISG_ATTR_DPL_LO +: 2]};
    end
    if (wb_wr && wb_adr == `ISG_ADR_GATE_OFF) gate_off_mem[gidx_r] <= wb_dat_w;
  end

  AST_IF_CLEAR:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_ENTER && !gate_trap) |=> !fl_r[`ISG_FLAG_IF] && start_r)
    else $error("interrupt gate entry left interrupts enabled");
  AST_IF_KEEP:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_ENTER && gate_trap) |=> fl_r[`ISG_FLAG_IF] == tfl_r[`ISG_FLAG_IF])
    else $error("trap gate entry changed the interrupt enable flag");
  AST_FLAT_ORDER:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_PUSH && !switch_r && idx_r == 3'd0) |-> stk_dat_w == tfl_r)
    else $error("same stack entry did not push flags first");
  AST_SWITCH_ORDER:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_PUSH && switch_r && idx_r == 3'd0) |-> stk_dat_w == {16'h0, tss_r})
    else $error("stack switch entry did not push old stack selector first");
  AST_ERR_LAST:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_PUSH && has_err_r && idx_r + 3'd1 == cnt_r) |-> stk_dat_w == err_r)
    else $error("error code not pushed last");
  AST_NO_NINE:
    assert property (@(posedge mclk) disable iff (!rst_b)
      start_r |-> vec_r != `ISG_VEC_SEG_OVR && !rsv_vec(vec_r))
    else $error("reserved vector was dispatched");
  AST_GATE_TARGET:
    assert property (@(posedge mclk) disable iff (!rst_b)
      state_r == ST_ENTER |=> cs_r == $past(gate_sel) && ip_r == $past(gate_off))
    else $error("handler target not taken from the gate");
  AST_TSS_LOAD:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_SAVE && switch_r) |=> ss_r == tss_sel_r[tcpl] && sp_r == tss_sp_r[tcpl])
    else $error("new stack not loaded from the task state segment");
  AST_RET_POP:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == ST_RET && !ret_switch) |=> sp_r == $past(sp_r) + `ISG_RET_FRAME)
    else $error("same level return did not step over the frame");
  AST_IRQ_RANGE:
    assert property (@(posedge mclk) disable iff (!rst_b)
      irq_ack |=> state_r == ST_GATE && vec_r >= `ISG_VEC_USER_LO)
    else $error("maskable request taken outside its vector range");

endmodule // isg_gate_unit

// ### design/isg_pkg.sv
// types shared by the gate entry/return unit
package isg_pkg;
  typedef enum logic [4:0] {
    CS_DIVIDE, CS_DEBUG, CS_NMI, CS_BREAKPOINT, CS_OVERFLOW, CS_RANGE,
    CS_INVALID_OP, CS_FPU_UNAVAIL, CS_INVALID_TSS, CS_SEG_ABSENT,
    CS_STACK_FAULT, CS_PROTECTION, CS_PAGING, CS_FPU_ERROR, CS_ALIGNMENT,
    CS_MACHINE_CHECK, CS_SIMD_FP
  } isg_cause_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_GATE, ST_SAVE, ST_PUSH, ST_ENTER, ST_POP, ST_RET, ST_HALT
  } isg_state_type;
endpackage

// ### verification/isg_stack_mem.sv
// stack memory model on the far side of the gate unit
`timescale 1ns/1ps
module isg_stack_mem (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        stk_cyc,
  input  wire logic        stk_we,
  input  wire logic [31:0] stk_adr,
  input  wire logic [31:0] stk_dat_w,
  input  wire logic        slow,
  output logic      [31:0] stk_dat_r,
  output logic             stk_ack,
  output logic             stk_err
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_r;
  logic        wait_r;
  // inverted data between answers so stale words never pass for fresh ones
  assign stk_dat_r = stk_ack ? rd_r : ~rd_r;
  assign stk_err   = 1'b0;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stk_ack <= 1'b0;
      wait_r  <= 1'b0;
    end else if (stk_cyc && !stk_ack && (wait_r || !slow)) begin
      stk_ack <= 1'b1;
      wait_r  <= 1'b0;
      if (stk_we) mem[stk_adr] = stk_dat_w;
      rd_r <= mem.exists(stk_adr) ? mem[stk_adr] : ~rd_r;
    end else begin
      stk_ack <= 1'b0;
      wait_r  <= stk_cyc && !stk_ack;
    end
  end
endmodule // isg_stack_mem

// ### verification/tb.sv
// bench for the gate entry/return unit
`timescale 1ns/1ps
`include "isg_cfg.svh"
module tb;
  import isg_pkg::*;
  logic          mclk = 0, rst_b = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, exc_valid = 0;
  logic          swi_valid = 0, handler_return_instr = 0, maskable_request_pin = 0, slow = 0;
  logic [3:0]    wb_sel = 4'hf;
  logic [7:0]    wb_adr = '0, swi_vec = '0, irq_vec = '0, cur_vec;
  logic [31:0]   wb_dat_w = '0, exc_code = '0, wb_dat_r, stk_adr, stk_dat_w, stk_dat_r;
  logic [31:0]   flags_word, instr_pointer, sp_m, rng = 32'h0000_a831;
  isg_cause_type exc_cause = CS_DIVIDE;
  logic [15:0]   code_sel;
  logic [1:0]    cur_level;
  logic          wb_ack, ev_ready, irq_ack, stk_cyc, stk_we, stk_ack, stk_err;
  logic          handler_start, halted;
  logic [63:0]   q[$];
  int            errors = 0, comparisons = 0, i;
  isg_gate_unit u_isg_gate_unit (.*);
  isg_stack_mem u_isg_stack_mem (.*);
  always #50 mclk = ~mclk;
  function automatic logic [31:0] nx(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, e);
    @(posedge mclk);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge mclk); while (wb_ack !== 1'b1);
    if (!w) chk(wb_dat_r, e);
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask
  task automatic pu(input logic [31:0] d);
    sp_m -= 32'h4;
    q.push_back({sp_m, d});
  endtask
  // pushes are compared in order as the memory accepts them
  always @(posedge mclk) begin
    if (stk_cyc && stk_we && stk_ack) begin
      chk(q.size() != 0, 1);
      chk(stk_adr, q[0][63:32]);
      chk(stk_dat_w, q[0][31:0]);
      void'(q.pop_front());
    end
  end
  task automatic go(input int k, input logic [7:0] rv, v, input bit e, t,
                    input logic [31:0] c, input logic [1:0] lv);
    logic [31:0] off;
    int          n;
    rng = nx(rng);
    off = rng;
    slow <= rng[3];
    bus(`ISG_ADR_CTRL, 1, {30'h0, lv}, 0);
    bus(`ISG_ADR_FLAGS, 1, 32'h0000_0202, 0);
    bus(`ISG_ADR_CODE_SEL, 1, {30'h4, lv}, 0);
    bus(`ISG_ADR_IP, 1, 32'h0000_0100, 0);
    bus(`ISG_ADR_STK_PTR, 1, 32'h0000_1000, 0);
    bus(`ISG_ADR_GATE_IDX, 1, {24'h0, v}, 0);
    bus(`ISG_ADR_GATE_OFF, 1, off, 0);
    bus(`ISG_ADR_GATE_ATTR, 1, {12'h0, 1'b1, t, 2'b11, 16'h0020}, 0);
    sp_m = lv != 0 ? 32'h0000_2000 : 32'h0000_1000;
    if (lv != 0) begin
      pu(32'h0);
      pu(32'h0000_1000);
    end
    pu(32'h0000_0202);
    pu({30'h4, lv});
    pu(32'h0000_0100);
    if (e) pu(c);
    @(posedge mclk);
    case (k)
      0: begin
        exc_valid <= 1;
        exc_cause <= isg_cause_type'(rv[4:0]);
        exc_code <= c;
      end
      1: begin
        swi_valid <= 1;
        swi_vec <= rv;
      end
      default: begin
        maskable_request_pin <= 1;
        irq_vec <= rv;
      end
    endcase
    @(posedge mclk);
    exc_valid <= 0;
    swi_valid <= 0;
    for (n = 0; n < 300 && handler_start !== 1'b1; n++) begin
      @(posedge mclk);
      if (irq_ack === 1'b1) maskable_request_pin <= 0;
    end
    maskable_request_pin <= 0;
    chk(n < 300, 1);
    chk(halted, 0);
    chk(cur_vec, v);
    chk(code_sel, 16'h0020);
    chk(instr_pointer, off);
    chk(flags_word[`ISG_FLAG_IF], t);
    chk(cur_level, 0);
    chk(q.size(), 0);
    // the handler discards its own error code before returning
    if (e) bus(`ISG_ADR_STK_PTR, 1, sp_m + 32'h4, 0);
    @(posedge mclk);
    handler_return_instr <= 1;
    @(posedge mclk);
    handler_return_instr <= 0;
    @(posedge mclk);
    for (n = 0; n < 300 && ev_ready !== 1'b1; n++) @(posedge mclk);
    chk(n < 300, 1);
    chk(instr_pointer, 32'h0000_0100);
    chk(code_sel, {30'h4, lv});
    chk(flags_word, 32'h0000_0202);
    chk(cur_level, lv);
    bus(`ISG_ADR_STK_PTR, 0, 0, 32'h0000_1000);
  endtask
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1;
    bus(8'h40, 0, 0, 0);
    bus(`ISG_ADR_FLAGS, 0, 0, `ISG_FLAGS_RST);
    bus(`ISG_ADR_TSS_BASE + 8'h04, 1, 32'h0000_2000, 0);
    for (i = 0; i < 17; i++)
      go(0, 8'(i), 8'(i < 8 ? i : i < 13 ? i + 2 : i + 3), (i > 7 && i < 13) || i == 14,
         i[0], nx(rng), 0);
    // an absent gate turns the event into a double fault with a zero code
    bus(`ISG_ADR_GATE_IDX, 1, 32'h0000_0013, 0);
    bus(`ISG_ADR_GATE_ATTR, 1, 32'h0000_0000, 0);
    go(0, 8'h10, 8'h08, 1, 0, 32'h0000_0000, 0);
    go(1, 8'h09, 8'h0d, 1, 0, 32'h0000_004a, 0);
    go(1, {1'b1, rng[6:0]}, {1'b1, rng[6:0]}, 0, 1, 0, 0);
    go(2, 8'h20, 8'h20, 0, 0, 0, 0);
    go(0, 8'h00, 8'h00, 0, 0, 0, 2);
    give_verdict;
  end
endmodule // tb
